// ---- core/bbsram_params.svh ----
`ifndef BBSRAM_PARAMS_SVH
`define BBSRAM_PARAMS_SVH

// ****************************************************************
// Address map
// ****************************************************************
`define BBS_ADDR_W        11
`define BBS_CTRL_ADDR     11'h7F8
`define BBS_SEC_ADDR      11'h7F9
`define BBS_MIN_ADDR      11'h7FA
`define BBS_HOUR_ADDR     11'h7FB
`define BBS_DAY_ADDR      11'h7FC
`define BBS_DATE_ADDR     11'h7FD
`define BBS_MONTH_ADDR    11'h7FE
`define BBS_YEAR_ADDR     11'h7FF
`define BBS_CLK_BASE_HI   8'hFF

// ****************************************************************
// Control byte fields and reset value
// ****************************************************************
`define BBS_CTRL_SETTIME  7
`define BBS_CTRL_HALTRD   6
`define BBS_CTRL_RESET    8'h00

// ****************************************************************
// Timing: oscillator rate and one-second tick
// ****************************************************************
`define BBS_CLK_HZ        100000000
`define BBS_TICK_SEC      1
`define BBS_TICK_CYCLES   (`BBS_CLK_HZ * `BBS_TICK_SEC)

`endif

// ---- core/bbsram_pkg.sv ----
package bbsram_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       cs_n;
    logic       output_enable_n;
    logic       store_strobe_n;
    logic [10:0] addr_bus;
    logic [7:0] data_in;
  } bbs_host_s;

  typedef struct packed {
    logic [7:0] data_out;
    logic [7:0] data_oe;
  } bbs_dq_s;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } bbs_time_s;

  typedef enum logic [1:0] {
    BBS_IDLE  = 2'b00,
    BBS_WRITE = 2'b01,
    BBS_READ  = 2'b11
  } bbs_mode_e;

endpackage : bbsram_pkg

// ---- core/bbsram_port.sv ----
`timescale 1ns/1ps
`include "bbsram_params.svh"
module bbsram_port
  import bbsram_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BBS_TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  // Host memory port
  input  wire bbsram_pkg::bbs_host_s  host_i,
  output bbsram_pkg::bbs_dq_s         dq_o,
  // Supply monitoring and one-second tick
  input  wire logic                   supply_fault_i,
  input  wire logic                   battery_low_i,
  output logic                        battery_low_flag_o,
  output logic                        tick_o
);
  import bbsram_pkg::*;

  initial
  begin
    if (TICK_CYCLES < 2)
      $error("TICK_CYCLES must be at least 2");
  end

  // ****************************************************************
  // Storage array
  // ****************************************************************
  logic [7:0] mem [0:2047];

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bbs_mode_e   mode;
    logic        wr_done;
    logic        bat_low;
    logic        bat_sampled;
    logic [31:0] tick_cnt;
    logic        tick;
    bbs_time_s   cnt;
    logic [7:0]  ctrl;
    logic        settime_q;
    logic [7:0]  rd_data;
  } bbs_state_s;

  bbs_state_s st;
  bbs_state_s next_st;

  // BCD increment with wrap; returns low value on wrap
  function automatic logic [7:0] bbs_bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                             input logic [7:0] low);
    logic [7:0] r;
    r = v;
    if (v >= top)
      r = low;
    else if (v[3:0] == 4'h9)
      r = {v[7:4] + 4'h1, 4'h0};
    else
      r = {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bbs_bcd_inc

  function automatic logic [7:0] bbs_month_len(input logic [7:0] month, input logic [7:0] year);
    logic [7:0] r;
    logic [7:0] ybin;
    ybin = ({4'h0, year[7:4]} * 8'h0A) + {4'h0, year[3:0]};
    case (month)
      8'h02:   r = (ybin[1:0] == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction : bbs_month_len

  function automatic logic bbs_is_clock(input logic [10:0] a);
    return a[10:3] == `BBS_CLK_BASE_HI;
  endfunction : bbs_is_clock

  // ****************************************************************
  // Host-side decode
  // ****************************************************************
  logic live;
  logic wr_act;
  logic rd_act;
  logic wr_commit;
  logic wr_allowed;

  assign live   = !supply_fault_i;
  assign wr_act = live && !host_i.cs_n && !host_i.store_strobe_n;
  assign rd_act = live && !host_i.cs_n && host_i.store_strobe_n;
  // Commit at the first rising edge of either strobe so late data still lands
  assign wr_commit  = (st.mode == BBS_WRITE) && !wr_act && live;
  assign wr_allowed = wr_commit && !st.bat_low;

  // ****************************************************************
  // Next state
  // ****************************************************************
  bbs_time_s  inc;
  logic       upd_ok;
  logic [7:0] wr_data;
  logic [10:0] wr_addr;

  // Address and data held by host through the write; latch on entry is not needed
  assign wr_addr = host_i.addr_bus;
  assign wr_data = host_i.data_in;

  // Falling set-time loads the counters from the bytes
  logic load_cnt;
  assign load_cnt = st.settime_q && !st.ctrl[`BBS_CTRL_SETTIME];
  // Halt or set-time freezes updates
  assign upd_ok = !st.ctrl[`BBS_CTRL_SETTIME] && !st.ctrl[`BBS_CTRL_HALTRD];

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    inc = st.cnt;

    // Mode tracking
    if (wr_act)
      next_st.mode = BBS_WRITE;
    else if (rd_act)
      next_st.mode = BBS_READ;
    else
      next_st.mode = BBS_IDLE;

    // Battery sampled once, in the first cycle after each reset
    if (!st.bat_sampled)
    begin
      next_st.bat_sampled = 1'b1;
      next_st.bat_low     = battery_low_i;
    end
    if (wr_commit && st.bat_low)
      next_st.bat_low = 1'b0;

    // One-second tick
    if (st.tick_cnt == 32'(TICK_CYCLES - 1))
    begin
      next_st.tick_cnt = 32'h0;
      next_st.tick     = 1'b1;
    end
    else
      next_st.tick_cnt = st.tick_cnt + 32'h1;

    // Hidden counters advance every second
    if (st.tick)
    begin
      inc.sec = bbs_bcd_inc(st.cnt.sec, 8'h59, 8'h00);
      if (st.cnt.sec == 8'h59)
      begin
        inc.min = bbs_bcd_inc(st.cnt.min, 8'h59, 8'h00);
        if (st.cnt.min == 8'h59)
        begin
          inc.hour = bbs_bcd_inc(st.cnt.hour, 8'h23, 8'h00);
          if (st.cnt.hour == 8'h23)
          begin
            inc.day  = bbs_bcd_inc(st.cnt.day, 8'h07, 8'h01);
            inc.date = bbs_bcd_inc(st.cnt.date, bbs_month_len(st.cnt.month, st.cnt.year), 8'h01);
            if (st.cnt.date >= bbs_month_len(st.cnt.month, st.cnt.year))
            begin
              inc.month = bbs_bcd_inc(st.cnt.month, 8'h12, 8'h01);
              if (st.cnt.month == 8'h12)
                inc.year = bbs_bcd_inc(st.cnt.year, 8'h99, 8'h00);
            end
          end
        end
      end
      next_st.cnt = inc;
    end
    if (load_cnt)
    begin
      next_st.cnt.sec   = mem[`BBS_SEC_ADDR];
      next_st.cnt.min   = mem[`BBS_MIN_ADDR];
      next_st.cnt.hour  = mem[`BBS_HOUR_ADDR];
      next_st.cnt.day   = mem[`BBS_DAY_ADDR];
      next_st.cnt.date  = mem[`BBS_DATE_ADDR];
      next_st.cnt.month = mem[`BBS_MONTH_ADDR];
      next_st.cnt.year  = mem[`BBS_YEAR_ADDR];
    end

    // Control register writes
    if (wr_allowed && wr_addr == `BBS_CTRL_ADDR)
      next_st.ctrl = wr_data;
    // Previous set-time bit, so its fall is seen for one cycle
    next_st.settime_q = st.ctrl[`BBS_CTRL_SETTIME];

    // Read data register
    next_st.rd_data = mem[host_i.addr_bus];
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st.mode        <= BBS_IDLE;
      st.wr_done     <= 1'b0;
      st.bat_low     <= 1'b0;
      st.bat_sampled <= 1'b0;
      st.tick_cnt    <= 32'h0;
      st.tick        <= 1'b0;
      st.cnt         <= '0;
      st.ctrl        <= `BBS_CTRL_RESET;
      st.settime_q   <= 1'b0;
      st.rd_data     <= 8'h00;
    end
    else
      st <= next_st;
  end

  // Array: a host write changes only the addressed byte, so a fault mid-write spares the rest
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_allowed)
      mem[wr_addr] <= wr_data;
    else if (st.tick && upd_ok)
    begin
      // All seven time bytes in the same edge, so no read sees a half update
      mem[`BBS_SEC_ADDR]   <= next_st.cnt.sec;
      mem[`BBS_MIN_ADDR]   <= next_st.cnt.min;
      mem[`BBS_HOUR_ADDR]  <= next_st.cnt.hour;
      mem[`BBS_DAY_ADDR]   <= next_st.cnt.day;
      mem[`BBS_DATE_ADDR]  <= next_st.cnt.date;
      mem[`BBS_MONTH_ADDR] <= next_st.cnt.month;
      mem[`BBS_YEAR_ADDR]  <= next_st.cnt.year;
    end
    if (wr_allowed && wr_addr == `BBS_CTRL_ADDR)
      mem[`BBS_CTRL_ADDR] <= wr_data;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb
  begin
    dq_o.data_out = st.rd_data;
    // Strobe low forces release even if oe is low
    dq_o.data_oe  = (rd_act && !host_i.output_enable_n) ? 8'hFF : 8'h00;
  end

  assign battery_low_flag_o = st.bat_low;
  assign tick_o             = st.tick;

endmodule : bbsram_port

// ---- dv/bbs_port_monitor.sv ----
`timescale 1ns/1ps
module bbs_port_monitor
#(
  parameter int unsigned TICK_CYCLES = 20
)
(
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // Host port, supply and tick
  input  wire bbsram_pkg::bbs_host_s host_i,
  input  wire bbsram_pkg::bbs_dq_s   dq_o,
  input  wire logic                  supply_fault_i,
  input  wire logic                  battery_low_i,
  input  wire logic                  battery_low_flag_o,
  input  wire logic                  tick_o
);
  import bbsram_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] cnt;
  logic        seen;
  wire         wr_act = !host_i.cs_n && !host_i.store_strobe_n && !supply_fault_i;
  // Cycles since the last tick; the first tick after reset has no reference
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i || tick_o)
      cnt <= '0;
    else
      cnt <= cnt + 32'h1;
    seen <= rst_i ? 1'h0 : (seen | tick_o);
  end
  sequence s_wr_commit;
    battery_low_flag_o && wr_act ##1 !wr_act && !supply_fault_i;
  endsequence
  a_oe_drive: assert property (!host_i.cs_n && host_i.store_strobe_n && !host_i.output_enable_n && !supply_fault_i
    |-> dq_o.data_oe == 8'hFF) else $error("bus not driven in read");
  a_oe_gate: assert property (host_i.store_strobe_n && host_i.output_enable_n |-> dq_o.data_oe == 8'h00)
    else $error("bus driven with output enable high");
  a_deselect_float: assert property (host_i.cs_n |-> dq_o.data_oe == 8'h00) else $error("bus driven deselected");
  a_strobe_float: assert property (!host_i.store_strobe_n |-> dq_o.data_oe == 8'h00)
    else $error("bus driven while strobe low");
  a_fault_float: assert property (supply_fault_i |-> dq_o.data_oe == 8'h00) else $error("bus driven in fault");
  a_flag_clear: assert property (s_wr_commit |=> !battery_low_flag_o) else $error("flag kept after write");
  a_flag_rise: assert property ($rose(battery_low_flag_o) |-> $past(rst_i, 2)) else $error("flag set late");
  a_tick_period: assert property (tick_o && seen |-> cnt == TICK_CYCLES - 1) else $error("tick early");
  a_tick_due: assert property (seen |-> cnt < TICK_CYCLES) else $error("tick missing");
endmodule : bbs_port_monitor

bind bbsram_port bbs_port_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_bbs_port_monitor (
  .sys_clk_i         (sys_clk_i),
  .rst_i             (rst_i),
  .host_i            (host_i),
  .dq_o              (dq_o),
  .supply_fault_i    (supply_fault_i),
  .battery_low_i     (battery_low_i),
  .battery_low_flag_o(battery_low_flag_o),
  .tick_o            (tick_o)
);

// ---- dv/bbs_host_model.sv ----
`timescale 1ns/1ps
module bbs_host_model
(
  input  wire logic                  sys_clk_i,
  input  wire bbsram_pkg::bbs_dq_s   dq_i,
  output bbsram_pkg::bbs_host_s      host_o
);
  import bbsram_pkg::*;
  initial host_o = '{1'h1, 1'h1, 1'h1, 11'h000, 8'h00};
  // Output enable stays high while writing; released data shows the inverse
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    host_o = '{1'h0, 1'h1, 1'h0, a, d};
    @(negedge sys_clk_i);
    host_o.store_strobe_n = 1'h1;
    @(negedge sys_clk_i);
    host_o = '{1'h1, 1'h1, 1'h1, a, ~d};
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] d, output logic [7:0] oe);
    @(negedge sys_clk_i);
    host_o = '{1'h0, 1'h0, 1'h1, a, ~host_o.data_in};
    @(negedge sys_clk_i);
    d = dq_i.data_out;
    oe = dq_i.data_oe;
    host_o.cs_n = 1'h1;
  endtask : rd
endmodule : bbs_host_model

// ---- dv/bbsram_port_tb.sv ----
`timescale 1ns/1ps
module bbsram_port_tb;
  import bbsram_pkg::*;
  logic       sys_clk_i;
  logic       rst_i;
  logic       supply_fault_i;
  logic       battery_low_i;
  logic       flag;
  logic       tick;
  bbs_host_s  host;
  bbs_dq_s    dq;
  int         n_fail;
  int         num_checks;
  int         cyc;
  logic [7:0] rv;
  logic [7:0] oe;
  logic [10:0] ta [4] = '{11'h000, 11'h3FF, 11'h400, 11'h7F7};
  logic [7:0] td [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h7E};
  logic [7:0] tv [7] = '{8'h58, 8'h10, 8'h12, 8'h03, 8'h15, 8'h06, 8'h24};
  initial
  begin
    sys_clk_i = 1'h0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  bbsram_port #(.TICK_CYCLES(20)) u_bbsram_port (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .host_i(host), .dq_o(dq),
    .supply_fault_i(supply_fault_i), .battery_low_i(battery_low_i), .battery_low_flag_o(flag), .tick_o(tick));
  bbs_host_model u_bbs_host_model (.sys_clk_i(sys_clk_i), .dq_i(dq), .host_o(host));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic rchk(input string nm, input logic [10:0] a, input logic [7:0] e);
    u_bbs_host_model.rd(a, rv, oe);
    chk({nm, " oe"}, 8'hFF, oe);
    chk(nm, e, rv);
  endtask : rchk
  task automatic do_reset(input logic bl);
    @(negedge sys_clk_i);
    rst_i = 1'h1;
    battery_low_i = bl;
    repeat (10) @(negedge sys_clk_i);
    rst_i = 1'h0;
    @(negedge sys_clk_i);
  endtask : do_reset
  task automatic wait_tick();
    for (int i = 0; i < 40 && tick !== 1'h1; i++)
      @(negedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : wait_tick
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      summarize();
    end
  end
  initial
  begin
    rst_i = 1'h1;
    supply_fault_i = 1'h0;
    battery_low_i = 1'h0;
    do_reset(1'h0);
    u_bbs_host_model.wr(11'h010, 8'h11);
    do_reset(1'h1);
    chk("flag", 8'h01, {7'h00, flag});
    u_bbs_host_model.wr(11'h010, 8'h5A);
    chk("flag", 8'h00, {7'h00, flag});
    rchk("blocked", 11'h010, 8'h11);
    u_bbs_host_model.wr(11'h010, 8'h5A);
    rchk("second", 11'h010, 8'h5A);
    $display("test battery done");
    for (int i = 0; i < 4; i++)
      u_bbs_host_model.wr(ta[i], td[i]);
    for (int i = 0; i < 4; i++)
      rchk("decode", ta[i], td[i]);
    $display("test decode done");
    supply_fault_i = 1'h1;
    u_bbs_host_model.wr(11'h010, 8'hEE);
    u_bbs_host_model.rd(11'h010, rv, oe);
    chk("fault oe", 8'h00, oe);
    supply_fault_i = 1'h0;
    rchk("fault", 11'h010, 8'h5A);
    $display("test fault done");
    u_bbs_host_model.wr(11'h7F8, 8'h80);
    for (int i = 0; i < 7; i++)
      u_bbs_host_model.wr(11'(11'h7F9 + i), tv[i]);
    u_bbs_host_model.wr(11'h7F8, 8'h00);
    wait_tick();
    rchk("sec", 11'h7F9, 8'h59);
    u_bbs_host_model.wr(11'h7F8, 8'h40);
    rchk("ctrl", 11'h7F8, 8'h40);
    wait_tick();
    wait_tick();
    rchk("halt", 11'h7F9, 8'h59);
    u_bbs_host_model.wr(11'h7F8, 8'h00);
    wait_tick();
    rchk("sec", 11'h7F9, 8'h02);
    rchk("min", 11'h7FA, 8'h11);
    rchk("hour", 11'h7FB, 8'h12);
    $display("test clock done");
    summarize();
  end
endmodule : bbsram_port_tb
